/* rtl/modbus_pkg.sv */
/*
  Shared constants for the register access request interpreter: frame byte
  offsets, function and exception codes, size limits and the state type.
  Assumes frames arrive and leave as byte streams with the header first.
*/
`default_nettype none

package modbus_pkg;

  // ****************************************************************
  // Frame byte offsets (request and response share the header)
  // ****************************************************************
  localparam logic [8:0] OFS_TID_H  = 9'h000;
  localparam logic [8:0] OFS_TID_L  = 9'h001;
  localparam logic [8:0] OFS_PID_H  = 9'h002;
  localparam logic [8:0] OFS_PID_L  = 9'h003;
  localparam logic [8:0] OFS_LEN_H  = 9'h004;
  localparam logic [8:0] OFS_LEN_L  = 9'h005;
  localparam logic [8:0] OFS_UID    = 9'h006;
  localparam logic [8:0] OFS_FN     = 9'h007;
  localparam logic [8:0] OFS_ADDR_H = 9'h008;
  localparam logic [8:0] OFS_ADDR_L = 9'h009;
  localparam logic [8:0] OFS_QTY_H  = 9'h00a;
  localparam logic [8:0] OFS_QTY_L  = 9'h00b;
  localparam logic [8:0] OFS_BC     = 9'h00c;
  localparam logic [8:0] OFS_DATA   = 9'h00d;
  localparam logic [8:0] OFS_DATA_W = 9'h00e;  // First low data byte
  localparam logic [8:0] OFS_RDATA  = 9'h009;  // Read data in response

  // ****************************************************************
  // Function and exception codes
  // ****************************************************************
  localparam logic [7:0] FN_READ      = 8'h03;
  localparam logic [7:0] FN_WR_ONE    = 8'h06;
  localparam logic [7:0] FN_WR_MANY   = 8'h10;
  localparam logic [7:0] EXC_FLAG     = 8'h80;
  localparam logic [7:0] EXC_NONE     = 8'h00;
  localparam logic [7:0] EXC_ILL_FN   = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_VAL  = 8'h03;
  localparam logic [7:0] EXC_DIAG     = 8'h04;

  // ****************************************************************
  // Size limits
  // ****************************************************************
  localparam logic [15:0] LEN_MIN      = 16'h0002;  // Unit id plus code
  localparam logic [15:0] LEN_MAX      = 16'h0100;
  localparam logic [15:0] LEN_FIXED    = 16'h0006;  // Unit id plus 5 PDU bytes
  localparam logic [15:0] LEN_WRN_BASE = 16'h0007;  // Unit id plus 6 PDU bytes
  localparam logic [15:0] HDR_BYTES    = 16'h0006;  // Bytes ahead of unit id
  localparam logic [15:0] RD_QTY_MAX   = 16'h007d;
  localparam logic [15:0] WR_QTY_MAX   = 16'h007b;
  localparam logic [8:0]  FRAME_MAX    = 9'h106;
  localparam logic [8:0]  TX_EXC_BYTES = 9'h009;
  localparam logic [8:0]  TX_WR_BYTES  = 9'h00c;
  localparam logic [8:0]  TX_RD_BASE   = 9'h009;

  typedef enum logic [3:0] {
    IDLE, DECODE, CHK_RD, CHK_EVAL, WR_RD, WR_DO, TX, FETCH, CAPT
  } state_e;

endpackage

`default_nettype wire

/* rtl/word_store.sv */
/*
  Small word memory holding the write data of one request until every
  word has been checked. Read data come out of a register one cycle after
  the read enable. Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module word_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 123,
  parameter int AW    = 7
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("word_store: DEPTH does not fit the address width");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0]            rd_data;
  } store_s;

  store_s s;
  store_s next_s;

  // ****************************************************************
  // Next state: one write port, one registered read port
  // ****************************************************************
  always_comb begin
    next_s = s;
    if (wr_en && (32'(wr_addr) < DEPTH)) begin
      next_s.cells[wr_addr] = wr_data;
    end
    if (rd_en && (32'(rd_addr) < DEPTH)) begin
      next_s.rd_data = s.cells[rd_addr];
    end
  end

  // Reset clears the read register too, so no stale word leaks out
  always_ff @(posedge clock) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data = s.rd_data;

endmodule // word_store

`default_nettype wire

/* rtl/modbus_tcp_register_server.sv */
/*
  Server-side interpreter for register access requests carried in TCP
  frames: header checks, decoding, validation and response building.
  Assumes the TCP stack delivers one request per packet as a byte stream
  with a last flag, and that a register map answers address and value
  checks combinationally and read data one cycle after a read strobe.
*/

// Summary of operation
// [R01] Transaction id copied unchanged into response.
// [R02] Protocol id returned exactly as received.
// [R03] Length equals unit id plus PDU, max 256.
// [R04] Unit id echoed, never interpreted.
// [R05] Only codes 03H, 06H, 10H are served.
// [R06] Exception code byte is request code plus 80H.
// [R07] Unknown function code gives exception 01H.
// [R08] Unmapped register address gives exception 02H.
// [R09] Count outside 1-125 or 1-123 gives 03H.
// [R10] Out-of-range write value gives 03H, no write.
// [R11] Priority: length drop, then 01H, 03H, 02H.
// [R12] Read reply: code, byte count, register contents.
// [R13] Single write reply mirrors the request.
// [R14] Multiple write reply: code, address, count.
// [R15] Malformed request: no register action, exception reply.
// [R16] Flagged self-diagnostic error answers every request exceptionally; the code answers only requests that pass the IP and length checks.
// [R17] Length field mismatching packet size: silent drop.
// [R18] Request for another IP address: silent drop.
// [R19] PDU sizes fixed per function code.
// [R20] PDU data part is 1 to 251 bytes.
// [R21] Read data ascending, high byte first.
// [R22] Client sends write data ascending, high first.
// [R23] Multi-byte fields travel most significant first.
`timescale 1ns/1ps
`default_nettype none

module modbus_tcp_register_server
  import modbus_pkg::*;
#(
  parameter int WR_DEPTH = 123
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_last,
  output logic             rx_ready,
  input  wire logic        dest_ip_match,
  input  wire logic        diag_error,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_last,
  input  wire logic        tx_ready,
  output logic      [15:0] map_addr,
  output logic      [15:0] map_wdata,
  output logic             map_rd_en,
  output logic             map_wr_en,
  input  wire logic [15:0] map_rdata,
  input  wire logic        map_addr_ok,
  input  wire logic        map_value_ok
);

  if (WR_DEPTH < 1 || WR_DEPTH > int'(WR_QTY_MAX)) begin : g_bad_depth
    $error("modbus_tcp_register_server: WR_DEPTH must be 1 to 123");
  end

  typedef struct packed {
    state_e      st;
    logic [15:0] tid;
    logic [15:0] pid;
    logic [15:0] len;
    logic [7:0]  uid;
    logic [7:0]  fn;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0]  bc;
    logic [8:0]  cnt;
    logic        too_long;
    logic        ip_ok;
    logic [7:0]  wd_hi;
    logic [6:0]  words;
    logic [6:0]  idx;
    logic        addr_bad;
    logic        data_bad;
    logic [15:0] map_addr;
    logic [7:0]  exc;
    logic [15:0] rd_word;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_last;
    logic [8:0]  tidx;
    logic [8:0]  tlen;
  } core_s;

  core_s       s;
  core_s       next_s;
  logic        mem_we;
  logic [6:0]  mem_waddr;
  logic [15:0] mem_wdata;
  logic [15:0] mem_rdata;
  logic        len_ok;
  logic        fn_known;
  logic        size_bad;
  logic        qty_bad;
  logic        rd_normal;
  logic        last_word;
  logic [15:0] len_out;
  logic [8:0]  data_ofs;

  // ****************************************************************
  // Request classification
  // ****************************************************************
  // Length field must agree with the packet and stay within bounds
  assign len_ok    = !s.too_long && (s.len >= LEN_MIN) && (s.len <= LEN_MAX) &&
                     ({7'h00, s.cnt} == s.len + HDR_BYTES);                     // [R17] [R03]
  assign fn_known  = (s.fn == FN_READ) || (s.fn == FN_WR_ONE) ||
                     (s.fn == FN_WR_MANY);                                      // [R05]
  // PDU size per code; a multi write also needs the byte count to agree
  assign size_bad  = (s.fn == FN_WR_MANY) ?
                     ((s.len != LEN_WRN_BASE + {8'h00, s.bc}) ||
                      ({8'h00, s.bc} != {s.qty[14:0], 1'b0})) :
                     (s.len != LEN_FIXED);                                      // [R19] [R20]
  assign qty_bad   = (s.fn == FN_READ) ? ((s.qty == 16'h0000) || (s.qty > RD_QTY_MAX)) :
                     (s.fn == FN_WR_MANY) ?
                     ((s.qty == 16'h0000) || (s.qty > WR_QTY_MAX) ||
                      (32'(s.qty) > WR_DEPTH)) : 1'b0;                         // [R09]
  assign rd_normal = (s.fn == FN_READ) && (s.exc == EXC_NONE);
  assign last_word = (s.idx == s.words - 7'h01);
  assign len_out   = {7'h00, s.tlen} - HDR_BYTES;
  assign data_ofs  = s.cnt - OFS_DATA_W;

  // Total response bytes for the outcome
  function automatic logic [8:0] tx_total(input logic [7:0] f, input logic [7:0] e,
                                          input logic [15:0] q);
    if (e != EXC_NONE) begin
      tx_total = TX_EXC_BYTES;
    end else if (f == FN_READ) begin
      tx_total = TX_RD_BASE + {q[7:0], 1'b0};
    end else begin
      tx_total = TX_WR_BYTES;
    end
  endfunction

  // Response byte at a header or echo position, most significant first
  function automatic logic [7:0] byte_at(input core_s c, input logic [15:0] lo);
    unique case (c.tidx)
      OFS_TID_H:  byte_at = c.tid[15:8];                                        // [R01] [R23]
      OFS_TID_L:  byte_at = c.tid[7:0];
      OFS_PID_H:  byte_at = c.pid[15:8];                                        // [R02]
      OFS_PID_L:  byte_at = c.pid[7:0];
      OFS_LEN_H:  byte_at = lo[15:8];                                           // [R03]
      OFS_LEN_L:  byte_at = lo[7:0];
      OFS_UID:    byte_at = c.uid;                                              // [R04]
      OFS_FN:     byte_at = (c.exc != EXC_NONE) ? c.fn + EXC_FLAG : c.fn;       // [R05] [R06]
      OFS_ADDR_H: byte_at = (c.exc != EXC_NONE) ? c.exc :
                            (c.fn == FN_READ) ? {c.qty[6:0], 1'b0} :            // [R12] [R21]
                            c.addr[15:8];                                       // [R13] [R14]
      OFS_ADDR_L: byte_at = c.addr[7:0];
      OFS_QTY_H:  byte_at = c.qty[15:8];
      OFS_QTY_L:  byte_at = c.qty[7:0];
      default:    byte_at = 8'h00;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s    = s;
    mem_we    = 1'b0;
    mem_waddr = 7'h00;
    mem_wdata = {s.wd_hi, rx_data};
    unique case (s.st)
      // Capture the frame; every field arrives high byte first
      IDLE: begin
        if (rx_valid) begin
          unique case (s.cnt)
            OFS_TID_H:  next_s.tid[15:8]  = rx_data;                            // [R23]
            OFS_TID_L:  next_s.tid[7:0]   = rx_data;
            OFS_PID_H:  next_s.pid[15:8]  = rx_data;
            OFS_PID_L:  next_s.pid[7:0]   = rx_data;
            OFS_LEN_H:  next_s.len[15:8]  = rx_data;
            OFS_LEN_L:  next_s.len[7:0]   = rx_data;
            OFS_UID:    next_s.uid        = rx_data;
            OFS_FN:     next_s.fn         = rx_data;
            OFS_ADDR_H: next_s.addr[15:8] = rx_data;
            OFS_ADDR_L: next_s.addr[7:0]  = rx_data;
            OFS_QTY_H:  next_s.qty[15:8]  = rx_data;
            OFS_QTY_L: begin
              next_s.qty[7:0] = rx_data;
              mem_wdata       = {s.qty[15:8], rx_data};
              mem_we          = (s.fn == FN_WR_ONE);
            end
            OFS_BC:     next_s.bc         = rx_data;
            default: begin
              // Words land in ascending order, high byte first
              if (s.cnt >= OFS_DATA && s.fn == FN_WR_MANY) begin
                if (s.cnt[0]) begin
                  next_s.wd_hi = rx_data;                                       // [R22]
                end else begin
                  mem_waddr = data_ofs[7:1];
                  mem_we    = (32'(data_ofs[8:1]) < WR_DEPTH);                  // [R22]
                end
              end
            end
          endcase
          if (s.cnt >= FRAME_MAX) begin
            next_s.too_long = 1'b1;
          end else begin
            next_s.cnt = s.cnt + 9'h001;
          end
          if (rx_last) begin
            next_s.ip_ok = dest_ip_match;
            next_s.st    = DECODE;
          end
        end
      end
      // Decide drop, early exception or register checks
      DECODE: begin
        next_s.tidx     = 9'h000;
        next_s.idx      = 7'h00;
        next_s.map_addr = s.addr;
        next_s.words    = (s.fn == FN_WR_ONE) ? 7'h01 : s.qty[6:0];
        if (!s.ip_ok || !len_ok) begin
          next_s.st       = IDLE;                                               // [R18] [R17] [R11]
          next_s.cnt      = 9'h000;
          next_s.too_long = 1'b0;
        end else begin
          if (diag_error) begin
            next_s.exc = EXC_DIAG;                                              // [R16]
          end else if (!fn_known) begin
            next_s.exc = EXC_ILL_FN;                                            // [R07] [R11]
          end else if (size_bad || qty_bad) begin
            next_s.exc = EXC_ILL_VAL;                                           // [R09] [R15]
          end
          if (diag_error || !fn_known || size_bad || qty_bad) begin
            next_s.st   = TX;
            next_s.tlen = TX_EXC_BYTES;
          end else begin
            next_s.st = CHK_RD;
          end
        end
      end
      CHK_RD: next_s.st = CHK_EVAL;
      // Every word is checked before any write, so a bad one writes nothing
      CHK_EVAL: begin
        if (!map_addr_ok) begin
          next_s.addr_bad = 1'b1;                                               // [R08]
        end
        if (s.fn != FN_READ && !map_value_ok) begin
          next_s.data_bad = 1'b1;                                               // [R10]
        end
        if (last_word) begin
          next_s.exc = next_s.data_bad ? EXC_ILL_VAL :
                       next_s.addr_bad ? EXC_ILL_ADDR : EXC_NONE;               // [R11]
          next_s.idx      = 7'h00;
          next_s.map_addr = s.addr;
          next_s.tlen     = tx_total(s.fn, next_s.exc, s.qty);
          next_s.st       = (next_s.exc == EXC_NONE && s.fn != FN_READ) ? WR_RD : TX;
        end else begin
          next_s.idx      = s.idx + 7'h01;
          next_s.map_addr = s.map_addr + 16'h0001;
          next_s.st       = CHK_RD;
        end
      end
      WR_RD: next_s.st = WR_DO;
      WR_DO: begin
        next_s.idx      = s.idx + 7'h01;
        next_s.map_addr = last_word ? s.addr : s.map_addr + 16'h0001;
        next_s.st       = last_word ? TX : WR_RD;
      end
      // Stream the response; read words are fetched one at a time
      TX: begin
        if (!s.tx_valid || tx_ready) begin
          if (s.tidx == s.tlen) begin
            next_s.tx_valid = 1'b0;
            next_s.tx_last  = 1'b0;
            next_s.st       = IDLE;
            next_s.cnt      = 9'h000;
            next_s.too_long = 1'b0;
            next_s.addr_bad = 1'b0;
            next_s.data_bad = 1'b0;
            next_s.exc      = EXC_NONE;
          end else if (rd_normal && s.tidx >= OFS_RDATA && s.tidx[0]) begin
            next_s.tx_valid = 1'b0;
            next_s.st       = FETCH;
          end else begin
            next_s.tx_valid = 1'b1;
            next_s.tx_data  = (rd_normal && s.tidx >= OFS_RDATA) ? s.rd_word[7:0] :
                              byte_at(s, len_out);                              // [R21]
            next_s.tx_last  = (s.tidx == s.tlen - 9'h001);
            next_s.tidx     = s.tidx + 9'h001;
          end
        end
      end
      FETCH: next_s.st = CAPT;
      CAPT: begin
        next_s.rd_word  = map_rdata;
        next_s.tx_valid = 1'b1;
        next_s.tx_data  = map_rdata[15:8];                                      // [R21]
        next_s.tx_last  = 1'b0;
        next_s.tidx     = s.tidx + 9'h001;
        next_s.map_addr = s.map_addr + 16'h0001;
        next_s.st       = TX;
      end
    endcase
  end

  // Synchronous reset brings the interpreter back to listening
  always_ff @(posedge clock) begin
    if (srst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  word_store #(
    .WIDTH (16),
    .DEPTH (WR_DEPTH),
    .AW    (7)
  ) u_store (
    .clock   (clock),
    .srst    (srst),
    .wr_en   (mem_we),
    .wr_addr (mem_waddr),
    .wr_data (mem_wdata),
    .rd_en   ((s.st == CHK_RD) || (s.st == WR_RD)),
    .rd_addr (s.idx),
    .rd_data (mem_rdata)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Input is stalled while a request is being served
  assign rx_ready  = (s.st == IDLE);
  assign tx_valid  = s.tx_valid;
  assign tx_data   = s.tx_data;
  assign tx_last   = s.tx_last;
  assign map_addr  = s.map_addr;
  assign map_wdata = mem_rdata;
  assign map_rd_en = (s.st == FETCH);
  assign map_wr_en = (s.st == WR_DO);                                           // [R15]

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_NO_WRITE_ON_FAULT: assert property (@(posedge clock) disable iff (srst) // [R10]
    map_wr_en |-> (s.exc == EXC_NONE && !s.addr_bad && !s.data_bad))
    else $error("register written although the request failed");
  AST_DROP_LENGTH: assert property (@(posedge clock) disable iff (srst) // [R17]
    (s.st == DECODE && !len_ok) |=> (s.st == IDLE && !tx_valid) ##1 !tx_valid)
    else $error("length mismatch did not drop the request");
  AST_DROP_IP: assert property (@(posedge clock) disable iff (srst) // [R18]
    (s.st == DECODE && !s.ip_ok) |=> (s.st == IDLE && !tx_valid))
    else $error("foreign address request was not ignored");
  AST_BAD_FUNCTION: assert property (@(posedge clock) disable iff (srst) // [R07]
    (s.st == DECODE && s.ip_ok && len_ok && !diag_error && !fn_known)
    |=> (s.st == TX && s.exc == EXC_ILL_FN && s.tlen == TX_EXC_BYTES))
    else $error("unknown function code not answered with 01H");
  AST_DIAG_EXC: assert property (@(posedge clock) disable iff (srst) // [R16]
    (s.st == DECODE && s.ip_ok && len_ok && diag_error) |=> (s.exc == EXC_DIAG))
    else $error("diagnostic error did not force an exception");
  AST_VALUE_BEATS_ADDR: assert property (@(posedge clock) disable iff (srst) // [R11]
    (s.st == CHK_EVAL && last_word && s.fn != FN_READ && !map_value_ok)
    |=> (s.exc == EXC_ILL_VAL && s.st == TX))
    else $error("value fault did not take priority over address fault");
  AST_TID_ECHO: assert property (@(posedge clock) disable iff (srst) // [R01]
    (tx_valid && s.tidx == OFS_TID_L) |-> (tx_data == s.tid[15:8]))
    else $error("transaction id high byte not echoed first");
  AST_PID_ECHO: assert property (@(posedge clock) disable iff (srst) // [R02]
    (tx_valid && s.tidx == OFS_LEN_H) |-> (tx_data == s.pid[7:0]))
    else $error("protocol id not echoed");
  AST_UID_ECHO: assert property (@(posedge clock) disable iff (srst) // [R04]
    (tx_valid && s.tidx == OFS_FN) |-> (tx_data == s.uid))
    else $error("unit id not echoed");
  AST_FN_BYTE: assert property (@(posedge clock) disable iff (srst) // [R06]
    (tx_valid && s.tidx == OFS_ADDR_H && s.exc != EXC_NONE) |-> (tx_data == s.fn + EXC_FLAG)
    ##1 (s.tidx == OFS_ADDR_H || tx_data == s.exc) [*1])
    else $error("exception function byte is not code plus 80H");
  AST_READ_COUNT: assert property (@(posedge clock) disable iff (srst) // [R12]
    (tx_valid && s.tidx == OFS_RDATA && rd_normal) |-> (tx_data == {s.qty[6:0], 1'b0}))
    else $error("read byte count is not twice the register count");
  AST_LAST_BYTE: assert property (@(posedge clock) disable iff (srst) // [R03]
    (tx_valid && tx_last) |-> (s.tidx == s.tlen && len_out <= LEN_MAX))
    else $error("last flag not on the final response byte");

endmodule // modbus_tcp_register_server

`default_nettype wire

/* verification/reg_map_model.sv */
/*
  Register map model: 16 words at 0100h, values above 03e8h refused.
  Assumes one clock shared with the interpreter.
*/
`timescale 1ns/1ps
`default_nettype none
module reg_map_model (
  input  wire logic        clock,
  input  wire logic [15:0] map_addr,
  input  wire logic [15:0] map_wdata,
  input  wire logic        map_rd_en,
  input  wire logic        map_wr_en,
  output logic      [15:0] map_rdata,
  output logic             map_addr_ok,
  output logic             map_value_ok
);
  logic [15:0] mem [16];
  // Address and range checks answer at once
  assign map_addr_ok  = (map_addr[15:4] == 12'h010);
  assign map_value_ok = (map_wdata <= 16'h03e8);
  initial begin
    map_rdata = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'ha500 + 16'(i);
  end
  // Data is valid one cycle after a strobe only; it toggles otherwise
  always @(posedge clock) begin
    map_rdata <= map_rd_en ? mem[map_addr[3:0]] : ~map_rdata;
    if (map_wr_en) mem[map_addr[3:0]] <= map_wdata;
  end
endmodule // reg_map_model
`default_nettype wire

/* verification/tb.sv */
/*
  Testbench for the request interpreter; the bench plays the client.
  Assumes the map model beside the design; tx_ready only drops under stall.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  typedef logic [7:0] bq_t[$];
  logic clock, srst, rx_valid, rx_last, rx_ready, dest_ip_match, diag_error;
  logic tx_valid, tx_last, tx_ready, stall, map_rd_en, map_wr_en, map_addr_ok, map_value_ok;
  logic [7:0] rx_data, tx_data;
  logic [15:0] map_addr, map_wdata, map_rdata;
  int mismatches, n_checks, cycles;
  modbus_tcp_register_server dut_u (.clock(clock), .srst(srst), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .dest_ip_match(dest_ip_match), .diag_error(diag_error), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .map_addr(map_addr),
    .map_wdata(map_wdata), .map_rd_en(map_rd_en), .map_wr_en(map_wr_en),
    .map_rdata(map_rdata), .map_addr_ok(map_addr_ok), .map_value_ok(map_value_ok));
  reg_map_model map_u (.clock(clock), .map_addr(map_addr), .map_wdata(map_wdata),
    .map_rd_en(map_rd_en), .map_wr_en(map_wr_en), .map_rdata(map_rdata),
    .map_addr_ok(map_addr_ok), .map_value_ok(map_value_ok));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Reply back-pressure: every other slot is refused while stall is set
  always @(posedge clock) tx_ready <= stall ? !tx_ready : 1'b1;
  // Header with fixed ids; length covers unit id plus PDU
  function automatic bq_t frame(bq_t pdu);
    bq_t f;
    f = '{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'(pdu.size() + 1), 8'h5a};
    return {f, pdu};
  endfunction
  // Request held until taken; reply collected up to its last byte
  task automatic xfer(bq_t req, logic ip, output bq_t rsp);
    rsp = {};
    dest_ip_match <= ip;
    foreach (req[i]) begin
      rx_valid <= 1'b1;
      rx_data <= req[i];
      rx_last <= (i == req.size() - 1);
      do @(posedge clock); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    repeat (400) begin
      @(posedge clock);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rsp.push_back(tx_data);
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_last === 1'b1) break;
    end
  endtask
  task automatic cmp(string nm, bq_t e, bq_t g);
    `CHK(nm, e.size(), g.size())
    foreach (e[i]) if (i < g.size()) `CHK(nm, e[i], g[i])
  endtask
  task automatic t_exc(string nm, bq_t pdu, logic [7:0] code);
    bq_t r;
    xfer(frame(pdu), 1'b1, r);
    cmp(nm, frame('{pdu[0] + 8'h80, code}), r);
  endtask
  task automatic t_read();
    bq_t r;
    xfer(frame('{8'h03, 8'h01, 8'h02, 8'h00, 8'h02}), 1'b1, r);
    cmp("read", frame('{8'h03, 8'h04, 8'ha5, 8'h02, 8'ha5, 8'h03}), r);
  endtask
  task automatic t_write();
    bq_t r;
    xfer(frame('{8'h06, 8'h01, 8'h05, 8'h00, 8'h64}), 1'b1, r);
    cmp("wr one", frame('{8'h06, 8'h01, 8'h05, 8'h00, 8'h64}), r);
    xfer(frame('{8'h10, 8'h01, 8'h06, 8'h00, 8'h02, 8'h04, 8'h00, 8'h64, 8'h00, 8'h78}),
         1'b1, r);
    cmp("wr many", frame('{8'h10, 8'h01, 8'h06, 8'h00, 8'h02}), r);
    t_exc("bad value", '{8'h06, 8'h01, 8'h08, 8'h04, 8'h00}, 8'h03);
    xfer(frame('{8'h03, 8'h01, 8'h05, 8'h00, 8'h04}), 1'b1, r);
    cmp("readback", frame('{8'h03, 8'h08, 8'h00, 8'h64, 8'h00, 8'h64, 8'h00, 8'h78,
        8'ha5, 8'h08}), r);
  endtask
  // Faults, one fault each and combined for priority
  task automatic t_faults();
    t_exc("bad fn", '{8'h05, 8'h02, 8'h00, 8'h00, 8'h01}, 8'h01);
    t_exc("qty 0", '{8'h03, 8'h01, 8'h00, 8'h00, 8'h00}, 8'h03);
    t_exc("qty 126", '{8'h03, 8'h01, 8'h00, 8'h00, 8'h7e}, 8'h03);
    t_exc("wr qty 0", '{8'h10, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, 8'h03);
    t_exc("bad addr", '{8'h03, 8'h02, 8'h00, 8'h00, 8'h01}, 8'h02);
    t_exc("qty vs addr", '{8'h03, 8'h02, 8'h00, 8'h00, 8'h00}, 8'h03);
    diag_error <= 1'b1;
    t_exc("diag", '{8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, modbus_pkg::EXC_DIAG);
    diag_error <= 1'b0;
  endtask
  task automatic t_drop();
    bq_t q;
    bq_t r;
    q = frame('{8'h03, 8'h01, 8'h00, 8'h00, 8'h01});
    xfer(q, 1'b0, r);
    `CHK("other ip", 0, r.size())
    q.push_back(8'h00);
    xfer(q, 1'b1, r);
    `CHK("len drop", 0, r.size())
  endtask
  // Replies under back-pressure, including the held exception byte
  task automatic t_stall();
    stall <= 1'b1;
    t_read();
    t_exc("stall fn", '{8'h05, 8'h02, 8'h00, 8'h00, 8'h01}, 8'h01);
    stall <= 1'b0;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, well above the fewer than 2000 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    {srst, stall, dest_ip_match} = 3'b101;
    {rx_valid, rx_last, diag_error, rx_data} = 11'h000;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    t_read();
    t_write();
    t_faults();
    t_drop();
    t_stall();
    stop_test();
  end
endmodule // tb
`default_nettype wire
